//--- src/iwwd_pkg.sv
// constants, field layouts and carrier types of the independent window watchdog
// Operation
// RULE_01 - count clock divided by 1..256
// RULE_02 - 14-bit counter decrements per prescaled tick
// RULE_03 - auto-start counts right after reset release
// RULE_04 - refresh is write 00h then FFh
// RULE_05 - reset stops counting, restores initial values
// RULE_06 - low-power halt only when enabled
// RULE_07 - register-start stops after underflow or error
// RULE_08 - programmable window start and end positions
// RULE_09 - fault on underflow or out-of-window refresh
// RULE_10 - select bit picks reset or nmi
// RULE_11 - counter status register returns counter value
// RULE_12 - separate event outputs for underflow, error
// RULE_13 - reset, interrupt and sleep-stop outputs
// RULE_14 - auto-start settings come from option word
// RULE_15 - register-start settings applied at refresh
// RULE_16 - stop bit 1 halts in low power
// RULE_17 - valid refresh reloads; wrong second write ignored
package iwwd_pkg;

    // register byte addresses
    localparam logic [7:0] IWWD_REFRESH_ADDR = 8'h00;
    localparam logic [7:0] IWWD_TIMING_ADDR = 8'h04;
    localparam logic [7:0] IWWD_ACTION_ADDR = 8'h08;
    localparam logic [7:0] IWWD_STOP_ADDR = 8'h0C;
    localparam logic [7:0] IWWD_STATUS_ADDR = 8'h10;
    localparam logic [7:0] IWWD_IRQ_STAT_ADDR = 8'h14;
    localparam logic [7:0] IWWD_IRQ_CLR_ADDR = 8'h18;
    localparam logic [7:0] IWWD_IRQ_EN_ADDR = 8'h1C;

    // refresh sequence bytes
    localparam logic [7:0] IWWD_REFRESH_FIRST = 8'h00;
    localparam logic [7:0] IWWD_REFRESH_SECOND = 8'hFF;

    // timing control field positions
    localparam int IWWD_DIV_LSB = 0;
    localparam int IWWD_TOUT_LSB = 8;
    localparam int IWWD_WEND_LSB = 10;
    localparam int IWWD_WSTART_LSB = 12;

    // interrupt status bit positions
    localparam int IWWD_IRQ_UNDERFLOW = 0;
    localparam int IWWD_IRQ_REFRESH_ERR = 1;

    // reset values
    localparam logic [13:0] IWWD_COUNT_RESET = 14'h3FFF;
    localparam logic [15:0] IWWD_TIMING_RESET = 16'h3300;
    localparam logic [7:0] IWWD_PRESCALE_RESET = 8'h00;

    // prescaler terminal counts (ratio minus one) per divide select
    localparam logic [7:0] IWWD_DIV1_M1 = 8'h00;
    localparam logic [7:0] IWWD_DIV16_M1 = 8'h0F;
    localparam logic [7:0] IWWD_DIV32_M1 = 8'h1F;
    localparam logic [7:0] IWWD_DIV64_M1 = 8'h3F;
    localparam logic [7:0] IWWD_DIV128_M1 = 8'h7F;
    localparam logic [7:0] IWWD_DIV256_M1 = 8'hFF;

    // reload values per timeout select (period minus one)
    localparam logic [13:0] IWWD_TOUT0_RELOAD = 14'h03FF;
    localparam logic [13:0] IWWD_TOUT1_RELOAD = 14'h0FFF;
    localparam logic [13:0] IWWD_TOUT2_RELOAD = 14'h1FFF;
    localparam logic [13:0] IWWD_TOUT3_RELOAD = 14'h3FFF;

    // counter state, gray along idle -> count -> halted
    typedef enum logic [1:0] {
        IWWD_IDLE = 2'b00,
        IWWD_COUNT = 2'b01,
        IWWD_HALTED = 2'b11
    } iwwd_state_t;

    // one full setting set, from option word or registers
    typedef struct packed {
        logic [3:0] divide_select;
        logic [1:0] timeout_select;
        logic [1:0] window_start_select;
        logic [1:0] window_end_select;
        logic action_select;
        logic low_power_stop_enable;
    } iwwd_cfg_t;

    // option memory word as seen by the block
    typedef struct packed {
        logic auto_start;
        iwwd_cfg_t auto_cfg;
    } iwwd_option_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic write;
        logic read;
    } iwwd_bus_t;

endpackage : iwwd_pkg

//--- src/iwwd_top.sv
// independent window watchdog: prescaler, down-counter, window check, registers
`timescale 1ns/1ns
module iwwd_top
(
    input wire logic clk,
    input wire logic reset,
    input wire logic watchdog_count_clock,
    input wire logic low_power_state,
    input wire iwwd_pkg::iwwd_option_t option_select_word0,
    input wire iwwd_pkg::iwwd_bus_t bus,
    output logic [31:0] rdata,
    output logic reset_request,
    output logic nmi_request,
    output logic sleep_stop_ctrl,
    output logic underflow_event,
    output logic refresh_error_event,
    output logic irq
);

    // synchronisers for the pin-side inputs
    logic wck_meta;
    logic wck_sync;
    logic wck_prev;
    logic lp_meta;
    logic lp_sync;

    // option capture after reset release
    logic opt_taken;
    logic auto_mode;

    // software registers
    logic [15:0] timing_control_register;
    logic action_control_register;
    logic low_power_count_stop_control;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic refresh_armed;

    // live settings and counting state
    iwwd_pkg::iwwd_cfg_t act_cfg;
    iwwd_pkg::iwwd_state_t state;
    logic [13:0] counter;
    logic [7:0] prescale;

    // two-flop sync of the count clock and low-power level
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wck_meta <= 1'b0;
            wck_sync <= 1'b0;
            wck_prev <= 1'b0;
            lp_meta <= 1'b0;
            lp_sync <= 1'b0;
        end
        else
        begin
            wck_meta <= watchdog_count_clock;
            wck_sync <= wck_meta;
            wck_prev <= wck_sync;
            lp_meta <= low_power_state;
            lp_sync <= lp_meta;
        end
    end

    // rising edge of the synced count clock is the source enable
    wire wck_edge = wck_sync & ~wck_prev;

    // address decode
    wire wr_refresh = bus.write & (bus.addr == iwwd_pkg::IWWD_REFRESH_ADDR);
    wire wr_timing = bus.write & (bus.addr == iwwd_pkg::IWWD_TIMING_ADDR);
    wire wr_action = bus.write & (bus.addr == iwwd_pkg::IWWD_ACTION_ADDR);
    wire wr_stop = bus.write & (bus.addr == iwwd_pkg::IWWD_STOP_ADDR);
    wire wr_irq_clr = bus.write & (bus.addr == iwwd_pkg::IWWD_IRQ_CLR_ADDR);
    wire wr_irq_en = bus.write & (bus.addr == iwwd_pkg::IWWD_IRQ_EN_ADDR);
    wire [7:0] wbyte = bus.wdata[7:0];

    // settings that software staged, taken over only at refresh
    wire iwwd_pkg::iwwd_cfg_t reg_cfg = '{
        divide_select: timing_control_register[iwwd_pkg::IWWD_DIV_LSB +: 4],
        timeout_select: timing_control_register[iwwd_pkg::IWWD_TOUT_LSB +: 2],
        window_start_select: timing_control_register[iwwd_pkg::IWWD_WSTART_LSB +: 2],
        window_end_select: timing_control_register[iwwd_pkg::IWWD_WEND_LSB +: 2],
        action_select: action_control_register,
        low_power_stop_enable: low_power_count_stop_control
    };

    // divide ratio decode; undefined codes fall back to divide by one
    logic [7:0] div_m1;
    always_comb
    begin
        case (act_cfg.divide_select)
            4'h0: div_m1 = iwwd_pkg::IWWD_DIV1_M1;
            4'h1: div_m1 = iwwd_pkg::IWWD_DIV16_M1;
            4'h2: div_m1 = iwwd_pkg::IWWD_DIV32_M1;
            4'h3: div_m1 = iwwd_pkg::IWWD_DIV64_M1;
            4'h4: div_m1 = iwwd_pkg::IWWD_DIV128_M1;
            4'h5: div_m1 = iwwd_pkg::IWWD_DIV256_M1;
            default: div_m1 = iwwd_pkg::IWWD_DIV1_M1;
        endcase
    end

    // reload value for the timeout select in force, and for the settings a start or refresh takes on
    logic [13:0] reload;
    logic [13:0] take_reload;
    // option word before capture, live settings in auto mode, staged registers otherwise
    wire iwwd_pkg::iwwd_cfg_t take_cfg = !opt_taken ? option_select_word0.auto_cfg
        : (auto_mode ? act_cfg : reg_cfg);
    always_comb
    begin
        case (act_cfg.timeout_select)
            2'h0: reload = iwwd_pkg::IWWD_TOUT0_RELOAD;
            2'h1: reload = iwwd_pkg::IWWD_TOUT1_RELOAD;
            2'h2: reload = iwwd_pkg::IWWD_TOUT2_RELOAD;
            default: reload = iwwd_pkg::IWWD_TOUT3_RELOAD;
        endcase
        // new period must come from the new settings, or a short timeout would start above its window
        case (take_cfg.timeout_select)
            2'h0: take_reload = iwwd_pkg::IWWD_TOUT0_RELOAD; // [RULE_17]
            2'h1: take_reload = iwwd_pkg::IWWD_TOUT1_RELOAD;
            2'h2: take_reload = iwwd_pkg::IWWD_TOUT2_RELOAD;
            default: take_reload = iwwd_pkg::IWWD_TOUT3_RELOAD;
        endcase
    end

    // window positions as fractions of the period, by shifts and one subtraction
    wire [13:0] pos_quarter = reload >> 2;
    wire [13:0] pos_half = reload >> 1;
    wire [13:0] pos_three_q = reload - pos_quarter;
    logic [13:0] win_hi;
    logic [13:0] win_lo;
    always_comb
    begin
        // start: counter value at or below which refresh becomes legal
        case (act_cfg.window_start_select) // [RULE_08]
            2'h0: win_hi = pos_three_q;
            2'h1: win_hi = pos_half;
            2'h2: win_hi = pos_quarter;
            default: win_hi = reload;
        endcase
        // end: counter value below which refresh is illegal again
        case (act_cfg.window_end_select) // [RULE_08]
            2'h0: win_lo = pos_three_q;
            2'h1: win_lo = pos_half;
            2'h2: win_lo = pos_quarter;
            default: win_lo = 14'h0000;
        endcase
    end

    // refresh while counting permitted only inside [win_lo, win_hi]
    wire in_window = (counter <= win_hi) & (counter >= win_lo);

    // a complete 00h/FFh sequence; any other second write is no refresh
    wire refresh_ok = wr_refresh & refresh_armed
        & (wbyte == iwwd_pkg::IWWD_REFRESH_SECOND); // [RULE_04] [RULE_17]

    // counting halts in low power only when the stop bit is set
    wire lp_halt = lp_sync & act_cfg.low_power_stop_enable; // [RULE_06] [RULE_16]
    wire counting = (state == iwwd_pkg::IWWD_COUNT);
    wire src_tick = counting & wck_edge & ~lp_halt;
    wire pre_tick = src_tick & (prescale == div_m1); // [RULE_01]

    // fault sources
    wire underflow = pre_tick & (counter == 14'h0000); // [RULE_09]
    wire refresh_err = refresh_ok & counting & ~in_window; // [RULE_09]
    wire fault = underflow | refresh_err;
    wire good_refresh = refresh_ok & ~refresh_err;

    // refresh sequence tracker: 00h arms, any other refresh write disarms
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            refresh_armed <= 1'b0;
        end
        else if (wr_refresh)
        begin
            refresh_armed <= (wbyte == iwwd_pkg::IWWD_REFRESH_FIRST); // [RULE_04]
        end
    end

    // option word caught once, on the first edge after reset release
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            opt_taken <= 1'b0;
            auto_mode <= 1'b0;
        end
        else if (!opt_taken)
        begin
            opt_taken <= 1'b1;
            auto_mode <= option_select_word0.auto_start;
        end
    end

    // software registers; writes in auto mode are kept but never applied, except the interrupt enable
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            timing_control_register <= iwwd_pkg::IWWD_TIMING_RESET; // [RULE_05]
            action_control_register <= 1'b0;
            low_power_count_stop_control <= 1'b0;
            irq_enable <= 2'b00;
        end
        else
        begin
            if (wr_timing)
            begin
                timing_control_register <= bus.wdata[15:0];
            end
            if (wr_action)
            begin
                action_control_register <= bus.wdata[0];
            end
            if (wr_stop)
            begin
                low_power_count_stop_control <= bus.wdata[0];
            end
            if (wr_irq_en)
            begin
                irq_enable <= bus.wdata[1:0];
            end
        end
    end

    // counter state machine and settings in force
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= iwwd_pkg::IWWD_IDLE; // [RULE_05]
            act_cfg <= '0;
            counter <= iwwd_pkg::IWWD_COUNT_RESET;
            prescale <= iwwd_pkg::IWWD_PRESCALE_RESET;
        end
        else
        begin
            case (state)
                iwwd_pkg::IWWD_IDLE:
                begin
                    if (!opt_taken && option_select_word0.auto_start)
                    begin
                        // auto-start: load option settings and run
                        act_cfg <= option_select_word0.auto_cfg; // [RULE_14]
                        counter <= take_reload;
                        state <= iwwd_pkg::IWWD_COUNT; // [RULE_03]
                    end
                    else if (opt_taken && !auto_mode && good_refresh)
                    begin
                        act_cfg <= reg_cfg; // [RULE_15]
                        counter <= take_reload; // [RULE_17]
                        prescale <= iwwd_pkg::IWWD_PRESCALE_RESET;
                        state <= iwwd_pkg::IWWD_COUNT; // [RULE_04]
                    end
                end
                iwwd_pkg::IWWD_COUNT:
                begin
                    if (fault && !auto_mode)
                    begin
                        // register-start stops on any fault
                        state <= iwwd_pkg::IWWD_HALTED; // [RULE_07]
                        prescale <= iwwd_pkg::IWWD_PRESCALE_RESET;
                    end
                    else if (good_refresh || fault)
                    begin
                        // refresh reloads; auto mode also reloads after a fault
                        if (!auto_mode)
                        begin
                            act_cfg <= reg_cfg; // [RULE_15]
                        end
                        counter <= take_reload; // [RULE_17]
                        prescale <= iwwd_pkg::IWWD_PRESCALE_RESET;
                    end
                    else if (pre_tick)
                    begin
                        counter <= counter - 14'h0001; // [RULE_02]
                        prescale <= iwwd_pkg::IWWD_PRESCALE_RESET;
                    end
                    else if (src_tick)
                    begin
                        prescale <= prescale + 8'h01; // [RULE_01]
                    end
                end
                iwwd_pkg::IWWD_HALTED:
                begin
                    // a fresh refresh sequence restarts from the top
                    if (good_refresh)
                    begin
                        act_cfg <= reg_cfg; // [RULE_15]
                        counter <= take_reload; // [RULE_17]
                        state <= iwwd_pkg::IWWD_COUNT; // [RULE_04]
                    end
                end
                default:
                begin
                    state <= iwwd_pkg::IWWD_IDLE;
                end
            endcase
        end
    end

    // fault routing and event outputs as one-cycle pulses, sleep-stop control as a level
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reset_request <= 1'b0;
            nmi_request <= 1'b0;
            underflow_event <= 1'b0;
            refresh_error_event <= 1'b0;
            sleep_stop_ctrl <= 1'b0;
        end
        else
        begin
            reset_request <= fault & ~act_cfg.action_select; // [RULE_10] [RULE_13]
            nmi_request <= fault & act_cfg.action_select; // [RULE_10] [RULE_13]
            underflow_event <= underflow; // [RULE_12]
            refresh_error_event <= refresh_err; // [RULE_12]
            sleep_stop_ctrl <= act_cfg.low_power_stop_enable; // [RULE_13]
        end
    end

    // sticky status; a new event beats a clear in the same cycle
    wire [1:0] irq_set = {refresh_err, underflow};
    wire [1:0] irq_clr = wr_irq_clr ? bus.wdata[1:0] : 2'b00;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irq_status <= 2'b00;
            irq <= 1'b0;
        end
        else
        begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
        end
    end

    // read mux; unmapped and write-only addresses read zero
    logic [31:0] rd_mux;
    always_comb
    begin
        case (bus.addr)
            iwwd_pkg::IWWD_TIMING_ADDR: rd_mux = {16'h0000, timing_control_register};
            iwwd_pkg::IWWD_ACTION_ADDR: rd_mux = {31'h00000000, action_control_register};
            iwwd_pkg::IWWD_STOP_ADDR: rd_mux = {31'h00000000, low_power_count_stop_control};
            iwwd_pkg::IWWD_STATUS_ADDR: rd_mux = {18'h00000, counter}; // [RULE_11]
            iwwd_pkg::IWWD_IRQ_STAT_ADDR: rd_mux = {30'h00000000, irq_status};
            iwwd_pkg::IWWD_IRQ_EN_ADDR: rd_mux = {30'h00000000, irq_enable};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdata <= 32'h00000000;
        end
        else
        begin
            rdata <= bus.read ? rd_mux : 32'h00000000;
        end
    end

endmodule : iwwd_top

//--- testbench/iwwd_monitor.sv
// port-level assertion checker for the window watchdog
`timescale 1ns/1ns
module iwwd_monitor
(
    input wire logic clk,
    input wire logic reset,
    input wire iwwd_pkg::iwwd_bus_t bus,
    input wire logic [31:0] rdata,
    input wire logic reset_request,
    input wire logic nmi_request,
    input wire logic underflow_event,
    input wire logic refresh_error_event,
    input wire logic irq
);
    localparam logic [7:0] ST = iwwd_pkg::IWWD_STATUS_ADDR; // counter status
    localparam logic [7:0] SP = iwwd_pkg::IWWD_STOP_ADDR; // stop control
    localparam logic [7:0] AC = iwwd_pkg::IWWD_ACTION_ADDR; // action select
    localparam logic [7:0] IE = iwwd_pkg::IWWD_IRQ_EN_ADDR; // interrupt enable
    logic stop_sh; // last stop bit written by software
    logic act_sh; // last action bit written by software
    logic [1:0] en_sh; // last interrupt enable written
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // shadow copies let readbacks be checked without seeing inside
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stop_sh <= 1'b0;
            act_sh <= 1'b0;
            en_sh <= 2'b00;
        end
        else if (bus.write)
        begin
            stop_sh <= (bus.addr == SP) ? bus.wdata[0] : stop_sh;
            act_sh <= (bus.addr == AC) ? bus.wdata[0] : act_sh;
            en_sh <= (bus.addr == IE) ? bus.wdata[1:0] : en_sh;
        end
    end
    a_rdata_idle_zero: assert property (!$past(bus.read) |-> rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_status_counter_width: assert property (bus.read && bus.addr == ST |=> rdata[31:14] == 18'h0)
        else $error("status read has bits above the counter");
    a_stop_bit_readback: assert property (bus.read && bus.addr == SP |=> rdata == {31'h0, stop_sh})
        else $error("stop control readback differs");
    a_action_bit_readback: assert property (bus.read && bus.addr == AC |=> rdata == {31'h0, act_sh})
        else $error("action select readback differs");
    a_irq_masked_off: assert property (en_sh == 2'b00 && $past(en_sh) == 2'b00 |-> !irq)
        else $error("interrupt high with all sources disabled");
    a_fault_one_action: assert property (!(reset_request && nmi_request))
        else $error("reset and nmi requested together");
    a_fault_has_cause: assert property (reset_request || nmi_request |-> underflow_event || refresh_error_event)
        else $error("fault action without underflow or refresh error");
    a_underflow_one_pulse: assert property (underflow_event |=> !underflow_event)
        else $error("underflow event longer than one cycle");
    a_error_one_pulse: assert property (refresh_error_event |=> !refresh_error_event)
        else $error("refresh error event longer than one cycle");
endmodule : iwwd_monitor

bind iwwd_top iwwd_monitor u_monitor (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .reset_request(reset_request), .nmi_request(nmi_request), .underflow_event(underflow_event),
    .refresh_error_event(refresh_error_event), .irq(irq));

//--- testbench/tb_top.sv
// self-checking bench for the window watchdog
`timescale 1ns/1ns
module tb_top;
    localparam logic [7:0] RF = iwwd_pkg::IWWD_REFRESH_ADDR;
    localparam logic [7:0] TM = iwwd_pkg::IWWD_TIMING_ADDR;
    localparam logic [7:0] AC = iwwd_pkg::IWWD_ACTION_ADDR;
    localparam logic [7:0] SP = iwwd_pkg::IWWD_STOP_ADDR;
    localparam logic [7:0] ST = iwwd_pkg::IWWD_STATUS_ADDR;
    localparam logic [7:0] IS = iwwd_pkg::IWWD_IRQ_STAT_ADDR;
    localparam logic [7:0] IC = iwwd_pkg::IWWD_IRQ_CLR_ADDR;
    localparam logic [7:0] IE = iwwd_pkg::IWWD_IRQ_EN_ADDR;
    logic clk = 1'b0; // 20 MHz system clock
    logic reset = 1'b1; // held for the first 12 cycles
    logic wcc = 1'b0; // slow count clock, made by hand per tick
    logic lps = 1'b0; // chip low-power state
    iwwd_pkg::iwwd_option_t opt = '0; // register-start first
    iwwd_pkg::iwwd_bus_t bus = '0; // idle bus
    logic [31:0] rdata;
    logic rst_req, nmi_req, stop_ctrl, uf_ev, err_ev, irq;
    logic [31:0] v, w; // status snapshots
    int n_errors = 0;
    int n_compared = 0;
    int n_uf = 0, n_err = 0, n_rst = 0, n_nmi = 0; // pulse tallies
    int cycles = 0; // hang guard
    always #25 clk = ~clk;
    iwwd_top dut (.clk(clk), .reset(reset), .watchdog_count_clock(wcc), .low_power_state(lps),
        .option_select_word0(opt), .bus(bus), .rdata(rdata), .reset_request(rst_req),
        .nmi_request(nmi_req), .sleep_stop_ctrl(stop_ctrl), .underflow_event(uf_ev),
        .refresh_error_event(err_ev), .irq(irq));
    // count one-cycle pulses so no pulse is missed between reads
    always @(posedge clk)
    begin
        n_uf <= n_uf + int'(uf_ev);
        n_err <= n_err + int'(err_ev);
        n_rst <= n_rst + int'(rst_req);
        n_nmi <= n_nmi + int'(nmi_req);
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        d = rdata;
    endtask : rd
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_val
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        chk_val(d, exp, what);
    endtask : chk_reg
    task automatic refresh();
        wr(RF, 32'h00);
        wr(RF, 32'hFF);
    endtask : refresh
    // each tick is 6 system cycles so the synchroniser sees every edge
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            wcc <= 1'b1;
            repeat (3) @(posedge clk);
            wcc <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : tick
    task automatic endt(input string name);
        $display("test %s finished, mismatches %0d", name, n_errors);
    endtask : endt
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        chk_reg(TM, 32'h3300, "timing reset");
        chk_reg(AC, 32'h0, "action reset");
        chk_reg(SP, 32'h0, "stop reset");
        chk_reg(ST, 32'h3FFF, "counter reset");
        chk_reg(IE, 32'h0, "enable reset");
        chk_reg(RF, 32'h0, "write-only read");
        chk_reg(8'h20, 32'h0, "unmapped read");
        endt("reset_values");
        tick(3);
        wr(RF, 32'hFF);
        tick(2);
        chk_reg(ST, 32'h3FFF, "idle until refresh");
        wr(TM, 32'h3C00);
        wr(AC, 32'h1);
        wr(IE, 32'h3);
        refresh();
        tick(3);
        chk_reg(ST, 32'h03FC, "counting after start");
        refresh();
        chk_reg(ST, 32'h03FF, "reload on refresh");
        wr(RF, 32'h00);
        wr(RF, 32'h55);
        wr(RF, 32'hFF);
        tick(1);
        chk_reg(ST, 32'h03FE, "broken sequence ignored");
        endt("refresh");
        for (int s = 1; s <= 5; s++)
        begin
            wr(TM, 32'h3C00 | s);
            refresh();
            rd(ST, v);
            tick(2 * (8 << s));
            rd(ST, w);
            chk_val(v - w, 32'h2, "prescaled decrements");
        end
        endt("divide");
        wr(TM, 32'h3C00);
        wr(SP, 32'h1);
        refresh();
        chk_reg(SP, 32'h1, "stop readback");
        chk_val(stop_ctrl, 32'h1, "stop control out");
        @(posedge clk);
        lps <= 1'b1;
        tick(4);
        chk_reg(ST, 32'h03FF, "held in low power");
        @(posedge clk);
        lps <= 1'b0;
        wr(SP, 32'h0);
        refresh();
        @(posedge clk);
        lps <= 1'b1;
        tick(4);
        chk_reg(ST, 32'h03FB, "counts in low power");
        @(posedge clk);
        lps <= 1'b0;
        endt("low_power");
        refresh();
        tick(1023);
        chk_val(n_uf, 32'h0, "no early underflow");
        tick(1);
        chk_val(n_uf, 32'h1, "underflow event");
        chk_val({n_nmi[15:0], n_rst[15:0]}, 32'h10000, "nmi selected");
        chk_val(irq, 32'h1, "irq on underflow");
        chk_reg(IS, 32'h1, "underflow status");
        rd(ST, v);
        tick(3);
        chk_reg(ST, v, "halted after underflow");
        wr(IC, 32'h1);
        chk_reg(IS, 32'h0, "status cleared");
        chk_val(irq, 32'h0, "irq cleared");
        endt("underflow");
        wr(AC, 32'h0);
        wr(IE, 32'h1);
        wr(TM, 32'h1C00);
        refresh();
        refresh();
        repeat (3) @(posedge clk);
        chk_val(n_err, 32'h1, "refresh error event");
        chk_val(n_rst, 32'h1, "reset selected");
        chk_reg(IS, 32'h2, "error status");
        chk_val(irq, 32'h0, "masked source");
        rd(ST, v);
        tick(3);
        chk_reg(ST, v, "halted after error");
        wr(IE, 32'h3);
        chk_reg(IS, 32'h2, "status kept");
        chk_val(irq, 32'h1, "unmasked source");
        wr(IC, 32'h2);
        chk_reg(IS, 32'h0, "error cleared");
        chk_val(irq, 32'h0, "irq dropped");
        wr(TM, 32'h3000);
        refresh();
        tick(256);
        refresh();
        repeat (3) @(posedge clk);
        chk_val(n_err, 32'h2, "refresh after window end");
        endt("refresh_error");
        @(posedge clk);
        reset <= 1'b1;
        opt <= '{auto_start: 1'b1, auto_cfg: '{divide_select: 4'h0, timeout_select: 2'h0,
            window_start_select: 2'h3, window_end_select: 2'h3, action_select: 1'b0,
            low_power_stop_enable: 1'b1}};
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        tick(4);
        chk_reg(ST, 32'h03FB, "auto start");
        chk_val(stop_ctrl, 32'h1, "option stop enable");
        chk_reg(IS, 32'h0, "status after reset");
        wr(TM, 32'h1);
        refresh();
        tick(2);
        chk_reg(ST, 32'h03FD, "option settings used");
        tick(1022);
        chk_val(n_rst, 32'h3, "auto underflow reset");
        tick(2);
        chk_reg(ST, 32'h03FD, "auto keeps counting");
        endt("auto_start");
        conclude();
    end
endmodule : tb_top
